// ==== design/qei_ctrl_pkg.sv ====
package qei_ctrl_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_INIT_VALUE = 4'h1;
    localparam logic [3:0] ADDR_GE_COMPARE = 4'h2;
    localparam logic [3:0] ADDR_POSITION = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int BIT_ENABLE = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_MODE_LO = 10;
    localparam int BIT_B_LEVEL = 9;
    localparam int BIT_A_LEVEL = 8;
    localparam logic [15:0] CONTROL_WMASK = 16'hbf7f;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;
    // ------------------------------------------------------------
    // init modes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_NONE = 3'h0;
    localparam logic [2:0] MODE_RESET_EVERY = 3'h1;
    localparam logic [2:0] MODE_LOAD_NEXT = 3'h2;
    localparam logic [2:0] MODE_LOAD_HOME1 = 3'h3;
    localparam logic [2:0] MODE_LOAD_HOME2 = 3'h4;
    localparam logic [2:0] MODE_RESET_GE = 3'h5;
    localparam logic [2:0] MODE_MODULO = 3'h6;
    localparam logic [2:0] MODE_RESERVED = 3'h7;
    // home tracker states, gray along the path
    typedef enum logic [1:0]
    {
        HOME_WAIT = 2'b00,
        HOME_SEEN = 2'b01,
        HOME_IDX1 = 2'b11,
        HOME_DONE = 2'b10
    } home_state_type;
endpackage : qei_ctrl_pkg

// ==== design/qei_home_tracker.sv ====
`timescale 1ns/1ps
`default_nettype none
module qei_home_tracker
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic home_rise,
    input wire logic index_event,
    output qei_ctrl_pkg::home_state_type state
);
    // ------------------------------------------------------------
    // counts index events after the latest home event
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= qei_ctrl_pkg::HOME_WAIT;
        else if (run)
        begin
            if (home_rise)
                state <= qei_ctrl_pkg::HOME_SEEN;
            else if (index_event)
            begin
                case (state)
                    qei_ctrl_pkg::HOME_SEEN: state <= qei_ctrl_pkg::HOME_IDX1;
                    qei_ctrl_pkg::HOME_IDX1: state <= qei_ctrl_pkg::HOME_DONE;
                    default: state <= state;
                endcase
            end
        end
    end
endmodule : qei_home_tracker
`default_nettype wire

// ==== design/qei_position_control.sv ====
// Overview of operation
// - enable bit set: counter follows encoder phases
// - enable clear: counter frozen, registers still readable and writable
// - control bits 14 and 7 read zero, writes ignored
// - idle stop set: counter halts while device idles
// - mode 000: index leaves position untouched
// - mode 001: every index resets position
// - mode 010: next index loads init value
// - mode 011: first index after home loads init value
// - mode 100: second index after home loads init value
// - mode 101: position equal to compare register resets it
// - mode 110: modulo counting; 111 reserved, software avoids it
// - phase B level qualifying index chosen by B match bit
// - phase A level qualifying index chosen by A match bit
`timescale 1ns/1ps
`default_nettype none
module qei_position_control
#(
    parameter int WIDTH = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic device_idle,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic index_input,
    input wire logic home_input,
    output logic [WIDTH-1:0] position,
    output logic index_seen,
    output logic counting
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (WIDTH != 16)
    begin : g_width_check
        $error("qei_position_control supports WIDTH 16 only");
    end

    logic [15:0] control_r;
    logic [WIDTH-1:0] init_value_r;
    logic [WIDTH-1:0] ge_compare_r;
    logic a_prev_r;
    logic b_prev_r;
    logic index_prev_r;
    logic home_prev_r;
    logic run;
    logic index_match;
    logic index_event;
    logic home_rise;
    logic step_up;
    logic step_dn;
    logic [2:0] mode;
    logic [WIDTH-1:0] position_nxt;
    qei_ctrl_pkg::home_state_type home_state;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            control_r <= qei_ctrl_pkg::CONTROL_RESET;
        else if (wr && addr == qei_ctrl_pkg::ADDR_CONTROL)
            control_r <= wdata & qei_ctrl_pkg::CONTROL_WMASK;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            init_value_r <= '0;
            ge_compare_r <= '0;
        end
        else if (wr)
        begin
            // writes land whether or not the counter runs
            if (addr == qei_ctrl_pkg::ADDR_INIT_VALUE)
                init_value_r <= wdata;
            if (addr == qei_ctrl_pkg::ADDR_GE_COMPARE)
                ge_compare_r <= wdata;
        end
    end

    // ------------------------------------------------------------
    // run qualification and event detection
    // ------------------------------------------------------------
    assign mode = control_r[qei_ctrl_pkg::BIT_MODE_LO +: 3];
    assign run = control_r[qei_ctrl_pkg::BIT_ENABLE]
        && !(control_r[qei_ctrl_pkg::BIT_IDLE_STOP] && device_idle);
    assign index_match = (phase_b_input == control_r[qei_ctrl_pkg::BIT_B_LEVEL])
        && (phase_a_input == control_r[qei_ctrl_pkg::BIT_A_LEVEL]);
    // rising edge so a long index pulse counts once
    assign index_event = index_input && !index_prev_r && index_match;
    assign home_rise = home_input && !home_prev_r;

    // quadrature decode: one step per single phase edge, no step when both phases change in one cycle
    always_comb
    begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if ((phase_a_input != a_prev_r) || (phase_b_input != b_prev_r))
        begin
            if ((phase_a_input != a_prev_r) && (phase_b_input != b_prev_r))
            begin
                step_up = 1'b0;
            end
            else if (phase_a_input != a_prev_r)
                step_up = (phase_a_input != phase_b_input);
            else
                step_dn = (phase_a_input != phase_b_input);
            if ((phase_a_input != a_prev_r) && (phase_b_input == b_prev_r))
                step_dn = !step_up;
            if ((phase_b_input != b_prev_r) && (phase_a_input == a_prev_r))
                step_up = !step_dn;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            a_prev_r <= 1'b0;
            b_prev_r <= 1'b0;
            index_prev_r <= 1'b0;
            home_prev_r <= 1'b0;
        end
        else
        begin
            a_prev_r <= phase_a_input;
            b_prev_r <= phase_b_input;
            index_prev_r <= index_input;
            home_prev_r <= home_input;
        end
    end

    qei_home_tracker u_home
    (
        .clk(clk),
        .rst(rst),
        .run(run),
        .home_rise(home_rise),
        .index_event(index_event),
        .state(home_state)
    );

    // ------------------------------------------------------------
    // position counter
    // ------------------------------------------------------------
    always_comb
    begin
        position_nxt = position;
        if (step_up)
        begin
            if (mode == qei_ctrl_pkg::MODE_MODULO && position == ge_compare_r)
                position_nxt = init_value_r;
            else
                position_nxt = position + 1'b1;
        end
        else if (step_dn)
        begin
            if (mode == qei_ctrl_pkg::MODE_MODULO && position == init_value_r)
                position_nxt = ge_compare_r;
            else
                position_nxt = position - 1'b1;
        end
        case (mode)
            qei_ctrl_pkg::MODE_NONE: position_nxt = position_nxt;
            qei_ctrl_pkg::MODE_RESET_EVERY:
                if (index_event)
                    position_nxt = '0;
            qei_ctrl_pkg::MODE_LOAD_NEXT:
                if (index_event)
                    position_nxt = init_value_r;
            qei_ctrl_pkg::MODE_LOAD_HOME1:
                if (index_event && !home_rise && home_state == qei_ctrl_pkg::HOME_SEEN)
                    position_nxt = init_value_r;
            qei_ctrl_pkg::MODE_LOAD_HOME2:
                if (index_event && !home_rise && home_state == qei_ctrl_pkg::HOME_IDX1)
                    position_nxt = init_value_r;
            qei_ctrl_pkg::MODE_RESET_GE:
                if (position == ge_compare_r)
                    position_nxt = '0;
            default: position_nxt = position_nxt;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            position <= '0;
        else if (run)
            position <= position_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            index_seen <= 1'b0;
            counting <= 1'b0;
        end
        else
        begin
            index_seen <= run && index_event;
            counting <= run;
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= qei_ctrl_pkg::UNMAPPED_READ;
        else if (rd)
        begin
            case (addr)
                qei_ctrl_pkg::ADDR_CONTROL: rdata <= control_r;
                qei_ctrl_pkg::ADDR_INIT_VALUE: rdata <= init_value_r;
                qei_ctrl_pkg::ADDR_GE_COMPARE: rdata <= ge_compare_r;
                qei_ctrl_pkg::ADDR_POSITION: rdata <= position;
                qei_ctrl_pkg::ADDR_STATUS: rdata <= {13'h0000, home_state, run};
                default: rdata <= qei_ctrl_pkg::UNMAPPED_READ;
            endcase
        end
        else
            rdata <= qei_ctrl_pkg::UNMAPPED_READ;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_write_ctrl;
        wr && addr == qei_ctrl_pkg::ADDR_CONTROL;
    endsequence
    property p_unused_zero;
        @(posedge clk) disable iff (rst) control_r[14] == 1'b0 && control_r[7] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused control bits set");
    property p_stopped;
        @(posedge clk) disable iff (rst) !control_r[qei_ctrl_pkg::BIT_ENABLE] |=> $stable(position);
    endproperty
    a_stopped: assert property (p_stopped) else $error("position moved while disabled");
    property p_idle_halt;
        @(posedge clk) disable iff (rst)
            control_r[qei_ctrl_pkg::BIT_IDLE_STOP] && device_idle |=> $stable(position);
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("position moved in idle stop");
    property p_reset_every;
        @(posedge clk) disable iff (rst)
            run && mode == qei_ctrl_pkg::MODE_RESET_EVERY && index_event |=> position == '0;
    endproperty
    a_reset_every: assert property (p_reset_every) else $error("index did not reset position");
    property p_load_next;
        @(posedge clk) disable iff (rst)
            run && mode == qei_ctrl_pkg::MODE_LOAD_NEXT && index_event |=> position == $past(init_value_r);
    endproperty
    a_load_next: assert property (p_load_next) else $error("index did not load init value");
    property p_reset_ge;
        @(posedge clk) disable iff (rst)
            run && mode == qei_ctrl_pkg::MODE_RESET_GE && position == ge_compare_r |=> position == '0;
    endproperty
    a_reset_ge: assert property (p_reset_ge) else $error("compare match did not reset");
    property p_index_qual;
        @(posedge clk) disable iff (rst)
            index_seen |-> $past(phase_a_input) == $past(control_r[qei_ctrl_pkg::BIT_A_LEVEL])
            && $past(phase_b_input) == $past(control_r[qei_ctrl_pkg::BIT_B_LEVEL]);
    endproperty
    a_index_qual: assert property (p_index_qual) else $error("index taken with wrong phases");
    property p_ctrl_write;
        @(posedge clk) disable iff (rst)
            s_write_ctrl |=> control_r == ($past(wdata) & qei_ctrl_pkg::CONTROL_WMASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
    property p_enabled;
        @(posedge clk) disable iff (rst)
            run && step_up && mode == qei_ctrl_pkg::MODE_NONE |=> position == $past(position) + 16'h0001;
    endproperty
    a_enabled: assert property (p_enabled) else $error("enabled counter did not step");
    sequence s_first_index;
        run && index_event && !home_rise && home_state == qei_ctrl_pkg::HOME_SEEN;
    endsequence
    sequence s_write_init;
        wr && addr == qei_ctrl_pkg::ADDR_INIT_VALUE;
    endsequence
    property p_mode_none;
        @(posedge clk) disable iff (rst)
            run && mode == qei_ctrl_pkg::MODE_NONE && !step_up && !step_dn |=> $stable(position);
    endproperty
    a_mode_none: assert property (p_mode_none) else $error("position moved without a step");
    property p_load_home1;
        @(posedge clk) disable iff (rst)
            run && mode == qei_ctrl_pkg::MODE_LOAD_HOME1 && index_event && !home_rise
            && home_state == qei_ctrl_pkg::HOME_SEEN |=> position == $past(init_value_r);
    endproperty
    a_load_home1: assert property (p_load_home1) else $error("first index after home did not load");
    property p_skip_home1;
        @(posedge clk) disable iff (rst)
            run && mode == qei_ctrl_pkg::MODE_LOAD_HOME1 && index_event && !step_up && !step_dn
            && home_state == qei_ctrl_pkg::HOME_WAIT |=> $stable(position);
    endproperty
    a_skip_home1: assert property (p_skip_home1) else $error("index loaded before any home");
    property p_load_home2;
        @(posedge clk) disable iff (rst)
            run && mode == qei_ctrl_pkg::MODE_LOAD_HOME2 && index_event && !home_rise
            && home_state == qei_ctrl_pkg::HOME_IDX1 |=> position == $past(init_value_r);
    endproperty
    a_load_home2: assert property (p_load_home2) else $error("second index after home did not load");
    property p_modulo_up;
        @(posedge clk) disable iff (rst)
            run && mode == qei_ctrl_pkg::MODE_MODULO && step_up && position == ge_compare_r
            |=> position == $past(init_value_r);
    endproperty
    a_modulo_up: assert property (p_modulo_up) else $error("modulo upper wrap wrong");
    property p_modulo_dn;
        @(posedge clk) disable iff (rst)
            run && mode == qei_ctrl_pkg::MODE_MODULO && step_dn && position == init_value_r
            |=> position == $past(ge_compare_r);
    endproperty
    a_modulo_dn: assert property (p_modulo_dn) else $error("modulo lower wrap wrong");
    property p_home_restart;
        @(posedge clk) disable iff (rst)
            run && home_rise |=> home_state == qei_ctrl_pkg::HOME_SEEN;
    endproperty
    a_home_restart: assert property (p_home_restart) else $error("home did not restart tracking");
    property p_home_count;
        @(posedge clk) disable iff (rst)
            s_first_index |=> home_state == qei_ctrl_pkg::HOME_IDX1;
    endproperty
    a_home_count: assert property (p_home_count) else $error("index after home not counted");
    property p_run_counts;
        @(posedge clk) disable iff (rst)
            run |=> counting;
    endproperty
    a_run_counts: assert property (p_run_counts) else $error("running not reported");
    property p_index_flag;
        @(posedge clk) disable iff (rst)
            run && index_event |=> index_seen;
    endproperty
    a_index_flag: assert property (p_index_flag) else $error("qualified index not flagged");
    property p_init_write;
        @(posedge clk) disable iff (rst)
            s_write_init |=> init_value_r == $past(wdata);
    endproperty
    a_init_write: assert property (p_init_write) else $error("init value write lost");
endmodule : qei_position_control
`default_nettype wire

// ==== verif/encoder_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module encoder_model
(
    input wire logic clk,
    output logic phase_a_input,
    output logic phase_b_input,
    output logic index_input,
    output logic home_input
);
    // ------------------------------------------------------------
    // phase walk
    // ------------------------------------------------------------
    logic [1:0] q;
    // gray walk 00,10,11,01: one quarter step up per move
    assign phase_a_input = q[1] ^ q[0];
    assign phase_b_input = q[1];
    initial
    begin
        q = 2'h0;
        index_input = 1'b0;
        home_input = 1'b0;
    end
    // slow spacing so every edge is seen on its own
    task automatic step(input logic up);
        @(posedge clk);
        q <= up ? q + 2'h1 : q - 2'h1;
        repeat (3) @(posedge clk);
    endtask : step
    task automatic pulse(input logic home);
        @(posedge clk);
        if (home)
            home_input <= 1'b1;
        else
            index_input <= 1'b1;
        repeat (2) @(posedge clk);
        home_input <= 1'b0;
        index_input <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
endmodule : encoder_model
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst, wr, rd, device_idle, index_seen, counting;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, position;
    logic [15:0] idx_cnt = 16'h0000;
    logic phase_a_input, phase_b_input, index_input, home_input;
    int miscompares = 0;
    int cmp_count = 0;
    always #50 clk = ~clk;
    qei_position_control #(.WIDTH(16)) i_qei_position_control
    (
        .clk(clk),
        .rst(rst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .device_idle(device_idle),
        .phase_a_input(phase_a_input),
        .phase_b_input(phase_b_input),
        .index_input(index_input),
        .home_input(home_input),
        .position(position),
        .index_seen(index_seen),
        .counting(counting)
    );
    encoder_model i_encoder_model
    (
        .clk(clk),
        .phase_a_input(phase_a_input),
        .phase_b_input(phase_b_input),
        .index_input(index_input),
        .home_input(home_input)
    );
    always @(posedge clk)
        if (index_seen === 1'b1)
            idx_cnt <= idx_cnt + 16'h0001;
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic chk_reg(input logic [3:0] a, input logic [15:0] exp, input string name);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask : chk_reg
    task automatic chk_pos(input logic [15:0] exp);
        chk_reg(qei_ctrl_pkg::ADDR_POSITION, exp, "position");
        check("position port", position, exp);
    endtask : chk_pos
    task automatic mv(input logic up, input int n);
        repeat (n) i_encoder_model.step(up);
    endtask : mv
    // enable set, levels either matching the phases now or not
    task automatic set_mode(input logic [2:0] m, input logic [1:0] flip);
        wr_reg(qei_ctrl_pkg::ADDR_CONTROL, {1'b1, 2'b00, m, {phase_b_input, phase_a_input} ^ flip, 8'h00});
    endtask : set_mode
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test();
    end
    initial
    begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        device_idle = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        chk_reg(qei_ctrl_pkg::ADDR_CONTROL, 16'h0000, "control reset");
        chk_reg(4'hf, 16'h0000, "unmapped");
        wr_reg(qei_ctrl_pkg::ADDR_CONTROL, 16'hfbff);
        chk_reg(qei_ctrl_pkg::ADDR_CONTROL, 16'hbb7f, "control bits");
        wr_reg(qei_ctrl_pkg::ADDR_CONTROL, 16'h0000);
        mv(1'b1, 2);
        chk_pos(16'h0000);
        wr_reg(qei_ctrl_pkg::ADDR_INIT_VALUE, 16'h1234);
        chk_reg(qei_ctrl_pkg::ADDR_INIT_VALUE, 16'h1234, "init value");
        set_mode(qei_ctrl_pkg::MODE_NONE, 2'h0);
        mv(1'b1, 3);
        mv(1'b0, 1);
        chk_pos(16'h0002);
        check("counting", {15'h0000, counting}, 16'h0001);
        wr_reg(qei_ctrl_pkg::ADDR_CONTROL, 16'ha000);
        device_idle <= 1'b1;
        mv(1'b1, 1);
        chk_pos(16'h0002);
        check("counting idle", {15'h0000, counting}, 16'h0000);
        device_idle <= 1'b0;
        mv(1'b1, 1);
        chk_pos(16'h0003);
        wr_reg(qei_ctrl_pkg::ADDR_CONTROL, 16'h8000);
        device_idle <= 1'b1;
        mv(1'b1, 1);
        chk_pos(16'h0004);
        device_idle <= 1'b0;
        set_mode(qei_ctrl_pkg::MODE_NONE, 2'h0);
        i_encoder_model.pulse(1'b0);
        chk_pos(16'h0004);
        check("index seen", idx_cnt, 16'h0001);
        set_mode(qei_ctrl_pkg::MODE_RESET_EVERY, 2'h1);
        i_encoder_model.pulse(1'b0);
        chk_pos(16'h0004);
        set_mode(qei_ctrl_pkg::MODE_RESET_EVERY, 2'h2);
        i_encoder_model.pulse(1'b0);
        chk_pos(16'h0004);
        check("index seen", idx_cnt, 16'h0001);
        set_mode(qei_ctrl_pkg::MODE_RESET_EVERY, 2'h0);
        i_encoder_model.pulse(1'b0);
        chk_pos(16'h0000);
        set_mode(qei_ctrl_pkg::MODE_LOAD_NEXT, 2'h0);
        i_encoder_model.pulse(1'b0);
        chk_pos(16'h1234);
        mv(1'b1, 1);
        set_mode(qei_ctrl_pkg::MODE_LOAD_HOME1, 2'h0);
        i_encoder_model.pulse(1'b0);
        chk_pos(16'h1235);
        i_encoder_model.pulse(1'b1);
        i_encoder_model.pulse(1'b0);
        chk_pos(16'h1234);
        mv(1'b1, 1);
        set_mode(qei_ctrl_pkg::MODE_LOAD_HOME2, 2'h0);
        i_encoder_model.pulse(1'b1);
        i_encoder_model.pulse(1'b0);
        chk_pos(16'h1235);
        i_encoder_model.pulse(1'b1);
        i_encoder_model.pulse(1'b0);
        chk_pos(16'h1235);
        i_encoder_model.pulse(1'b0);
        chk_pos(16'h1234);
        chk_reg(qei_ctrl_pkg::ADDR_STATUS, {13'h0000, qei_ctrl_pkg::HOME_DONE, 1'b1}, "status");
        wr_reg(qei_ctrl_pkg::ADDR_GE_COMPARE, 16'h1236);
        chk_reg(qei_ctrl_pkg::ADDR_GE_COMPARE, 16'h1236, "ge compare");
        set_mode(qei_ctrl_pkg::MODE_RESET_GE, 2'h0);
        mv(1'b1, 1);
        chk_pos(16'h1235);
        mv(1'b1, 1);
        chk_pos(16'h0000);
        wr_reg(qei_ctrl_pkg::ADDR_INIT_VALUE, 16'h0002);
        wr_reg(qei_ctrl_pkg::ADDR_GE_COMPARE, 16'h0004);
        set_mode(qei_ctrl_pkg::MODE_MODULO, 2'h0);
        mv(1'b1, 4);
        chk_pos(16'h0004);
        mv(1'b1, 1);
        chk_pos(16'h0002);
        mv(1'b0, 1);
        chk_pos(16'h0004);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
